// ### rtl/eelsr_pkg.sv
// Constants for the EEE and link status register group.
// Assumes one core clock and one management clock from the host.
package eelsr_pkg;
	// Register offsets in the management address space
	localparam logic [15:0] OFF_PARTNER = 16'h8002;
	localparam logic [15:0] OFF_RESOLVED = 16'h8008;
	localparam logic [15:0] OFF_SQ_ERR = 16'h8402;
	localparam logic [15:0] OFF_DET_EN = 16'h8E27;
	localparam logic [15:0] OFF_DOWN_LAT = 16'h8E38;
	localparam logic [15:0] OFF_CLK_STOP = 16'h9400;
	// Values after reset
	localparam logic [15:0] DET_EN_RST = 16'h003D;
	localparam logic [15:0] CLK_STOP_RST = 16'h0400;
	// Field positions
	localparam int POS_FAST_ETH = 1;
	localparam int POS_GIG_COPPER = 2;
	localparam int POS_TENGIG_SERIAL = 6;
	localparam int POS_RESOLVED = 0;
	localparam int SQ_ERR_W = 8;
	localparam int DET_EN_W = 8;
	localparam int POS_PCS_ERR_EN = 7;
	localparam int POS_SLICER_STUCK_EN = 5;
	localparam int POS_SLICER_ZERO_EN = 3;
	localparam int POS_SLICER_INVALID_EN = 1;
	localparam int POS_DOWN_LAT = 13;
	localparam int POS_CLK_STOP = 10;
	// Management frame layout and counts
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [3:0] OP_LAST = 4'h2;
	localparam logic [3:0] HDR_LAST = 4'hC;
	localparam logic [3:0] DATA_LAST = 4'hF;
	localparam logic [4:0] PHY_ADDR = 5'h00;
	localparam logic [4:0] MMD_DEV = 5'h1E;
	localparam logic [1:0] OP_ADDR = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_RD_INC = 2'h2;
	// Management frame states
	typedef enum logic [1:0] {
		M_IDLE,
		M_HDR,
		M_TA,
		M_DATA
	} eelsr_mdc_e;
endpackage

// ### rtl/eelsr_regs.sv
// EEE partner, signal quality, link loss and clock stop registers.
// Assumes a Clause 45 style serial management host on mdc/mdio and
// status inputs that come from logic on the core clock.
//
// Summary of operation
// - Partner EEE ability loaded from autonegotiation
// - Bit 1 shows partner fast Ethernet EEE
// - Bits 2..6 show other partner technologies
// - Bit 0 shows resolved technology EEE capable
// - Eight bit error reading, zero without link
// - Each link loss source has own enable
// - Bit 7 enables PCS receive error source
// - Bit 5 enables slicer output stuck source
// - Bit 3 enables slicer input zero source
// - Bit 1 enables slicer invalid level source
// - Enable register resets to 003D, upper zero
// - Link down latch holds until link-up
// - Clock may stop in idle only if enabled
// - Clock stop register resets 0400, bit 10
`timescale 1ns/100ps
`default_nettype none
module eelsr_regs (
	input wire logic clock,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [5:0] an_partner_eee,
	input wire logic an_partner_valid,
	input wire logic link_up,
	input wire logic link_up_100,
	input wire logic link_up_start,
	input wire logic eee_resolved,
	input wire logic [7:0] sq_err_in,
	input wire logic rx_lpi,
	input wire logic pcs_rx_error,
	input wire logic slicer_out_stuck,
	input wire logic slicer_in_zero,
	input wire logic slicer_in_invalid,
	output logic early_link_down_latched,
	output logic link_loss,
	output logic rx_clk_stop_allowed,
	output logic rx_clk_halt
);
	import eelsr_pkg::*;

	typedef struct packed {
		logic wt_meta;
		logic wt_sync;
		logic wt_prev;
		logic rt_meta;
		logic rt_sync;
		logic rt_prev;
		logic ack;
		logic [15:0] rdata;
		logic [5:0] partner;
		logic resolved;
		logic [7:0] sq_err;
		logic [7:0] det_en;
		logic stop_en;
		logic down_lat;
		logic loss;
		logic halt;
	} eelsr_core_s;

	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic a_meta;
		logic a_sync;
		logic wtog;
		logic rtog;
		logic mine;
		logic oe;
		logic dout_bit;
		eelsr_mdc_e st;
		logic [5:0] pre;
		logic [3:0] cnt;
		logic [1:0] op;
		logic [15:0] sh;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] dout;
	} eelsr_mdc_s;

	eelsr_core_s c;
	eelsr_core_s n;
	eelsr_mdc_s m;
	eelsr_mdc_s nm;
	logic wr_ev;
	logic rd_ev;
	logic det;

	// Read view of the group; unmapped offsets read zero
	function automatic logic [15:0] read_word(input eelsr_core_s s, input logic [15:0] a);
		logic [15:0] w;
		w = 16'h0000;
		case (a)
			OFF_PARTNER: w[POS_TENGIG_SERIAL:POS_FAST_ETH] = s.partner;
			OFF_RESOLVED: w[POS_RESOLVED] = s.resolved;
			OFF_SQ_ERR: w[SQ_ERR_W-1:0] = s.sq_err;
			OFF_DET_EN: w[DET_EN_W-1:0] = s.det_en;
			OFF_DOWN_LAT: w[POS_DOWN_LAT] = s.down_lat;
			OFF_CLK_STOP: w[POS_CLK_STOP] = s.stop_en;
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// Toggle edges from the management side, after two flops
	assign wr_ev = c.wt_sync ^ c.wt_prev;
	assign rd_ev = c.rt_sync ^ c.rt_prev;

	// Link loss sources, each gated by its own enable
	assign det = (pcs_rx_error & c.det_en[POS_PCS_ERR_EN])
		| (slicer_out_stuck & c.det_en[POS_SLICER_STUCK_EN])
		| (slicer_in_zero & c.det_en[POS_SLICER_ZERO_EN])
		| (slicer_in_invalid & c.det_en[POS_SLICER_INVALID_EN]);

	// Core side next state
	always_comb begin
		n = c;
		n.wt_meta = m.wtog;
		n.wt_sync = c.wt_meta;
		n.wt_prev = c.wt_sync;
		n.rt_meta = m.rtog;
		n.rt_sync = c.rt_meta;
		n.rt_prev = c.rt_sync;
		// Address and data stand still from the toggle until the next frame
		if (wr_ev) begin
			if (m.addr == OFF_DET_EN) begin
				n.det_en = m.wdata[DET_EN_W-1:0];
			end
			if (m.addr == OFF_CLK_STOP) begin
				n.stop_en = m.wdata[POS_CLK_STOP];
			end
		end
		// Status registers take no write at all
		if (rd_ev) begin
			n.rdata = read_word(c, m.addr);
			n.ack = ~c.ack;
		end
		if (an_partner_valid) begin
			n.partner = an_partner_eee;
		end
		n.resolved = link_up & eee_resolved;
		n.sq_err = link_up_100 ? sq_err_in : 8'h00;
		n.loss = det;
		// Set after clear so a loss in the link-up cycle is kept
		if (link_up_start) begin
			n.down_lat = 1'b0;
		end
		if (det) begin
			n.down_lat = 1'b1;
		end
		n.halt = c.stop_en & rx_lpi;
		if (rst) begin
			n = '0;
			n.det_en = DET_EN_RST[DET_EN_W-1:0];
			n.stop_en = CLK_STOP_RST[POS_CLK_STOP];
		end
	end

	// Core side registers
	always_ff @(posedge clock) begin
		c <= n;
	end

	// Management side next state
	always_comb begin
		logic [15:0] word;
		word = 16'hFFFF;
		nm = m;
		nm.rst_meta = rst;
		nm.rst_sync = m.rst_meta;
		nm.a_meta = c.ack;
		nm.a_sync = m.a_meta;
		case (m.st)
			M_IDLE: begin
				nm.oe = 1'b0;
				if (mdio_in) begin
					if (m.pre != PRE_LEN) begin
						nm.pre = m.pre + 6'h01;
					end
				end else begin
					nm.pre = 6'h00;
					if (m.pre == PRE_LEN) begin
						nm.st = M_HDR;
						nm.cnt = 4'h0;
					end
				end
			end
			M_HDR: begin
				nm.sh = {m.sh[14:0], mdio_in};
				nm.cnt = m.cnt + 4'h1;
				// Ask for read data early so it crosses before turnaround
				if (m.cnt == OP_LAST) begin
					nm.op = {m.sh[0], mdio_in};
					if (m.sh[0]) begin
						nm.rtog = ~m.rtog;
					end
				end
				if (m.cnt == HDR_LAST) begin
					nm.mine = ~m.sh[11] & (m.sh[8:4] == PHY_ADDR) & ({m.sh[3:0], mdio_in} == MMD_DEV);
					nm.st = M_TA;
					nm.cnt = 4'h0;
				end
			end
			M_TA: begin
				nm.cnt = m.cnt + 4'h1;
				if (m.cnt == 4'h0) begin
					nm.oe = m.mine & m.op[1];
					nm.dout_bit = 1'b0;
				end else begin
					// Unanswered request reads as an undriven line
					if (m.a_sync == m.rtog) begin
						word = c.rdata;
					end
					nm.dout_bit = word[15];
					nm.dout = {word[14:0], 1'b0};
					nm.st = M_DATA;
					nm.cnt = 4'h0;
				end
			end
			M_DATA: begin
				nm.sh = {m.sh[14:0], mdio_in};
				nm.dout_bit = m.dout[15];
				nm.dout = {m.dout[14:0], 1'b0};
				nm.cnt = m.cnt + 4'h1;
				if (m.cnt == DATA_LAST) begin
					nm.oe = 1'b0;
					nm.st = M_IDLE;
					nm.pre = 6'h00;
					if (m.mine) begin
						case (m.op)
							OP_ADDR: nm.addr = {m.sh[14:0], mdio_in};
							OP_WRITE: begin
								nm.wdata = {m.sh[14:0], mdio_in};
								nm.wtog = ~m.wtog;
							end
							OP_RD_INC: nm.addr = m.addr + 16'h0001;
							default: nm.addr = m.addr;
						endcase
					end
				end
			end
			default: nm.st = M_IDLE;
		endcase
		if (m.rst_sync) begin
			nm = '0;
			nm.rst_meta = rst;
			nm.rst_sync = m.rst_meta;
		end
	end

	// Management side registers on the host clock
	always_ff @(posedge mdc) begin
		m <= nm;
	end

	// Outputs come straight from flops
	assign mdio_out = m.dout_bit;
	assign mdio_oe = m.oe;
	assign early_link_down_latched = c.down_lat;
	assign link_loss = c.loss;
	assign rx_clk_stop_allowed = c.stop_en;
	assign rx_clk_halt = c.halt;

	// Checks on the core side
	property p_partner_load;
		@(posedge clock) disable iff (rst) an_partner_valid |=> c.partner == $past(an_partner_eee);
	endproperty
	a_partner_load: assert property (p_partner_load)
		else $error("partner ability not loaded");

	property p_partner_fast;
		@(posedge clock) disable iff (rst)
		(rd_ev && m.addr == OFF_PARTNER) |=> c.rdata[POS_FAST_ETH] == $past(c.partner[0]);
	endproperty
	a_partner_fast: assert property (p_partner_fast)
		else $error("fast Ethernet partner bit misplaced");

	property p_partner_upper;
		@(posedge clock) disable iff (rst)
		(rd_ev && m.addr == OFF_PARTNER) |=> c.rdata[POS_TENGIG_SERIAL:POS_GIG_COPPER] == $past(c.partner[5:1]);
	endproperty
	a_partner_upper: assert property (p_partner_upper)
		else $error("upper partner bits misplaced");

	property p_resolved;
		@(posedge clock) disable iff (rst) ##1 c.resolved == $past(link_up && eee_resolved);
	endproperty
	a_resolved: assert property (p_resolved)
		else $error("resolved bit wrong");

	property p_sq_err;
		@(posedge clock) disable iff (rst) !link_up_100 |=> c.sq_err == 8'h00;
	endproperty
	a_sq_err: assert property (p_sq_err)
		else $error("error reading shown without link");

	property p_gate;
		@(posedge clock) disable iff (rst) !det |=> !c.loss;
	endproperty
	a_gate: assert property (p_gate)
		else $error("link loss without enabled source");

	property p_pcs_err;
		@(posedge clock) disable iff (rst)
		(pcs_rx_error && c.det_en[POS_PCS_ERR_EN]) |=> c.loss && c.down_lat;
	endproperty
	a_pcs_err: assert property (p_pcs_err)
		else $error("PCS error source missed");

	property p_stuck;
		@(posedge clock) disable iff (rst)
		(slicer_out_stuck && c.det_en[POS_SLICER_STUCK_EN]) |=> c.loss;
	endproperty
	a_stuck: assert property (p_stuck)
		else $error("stuck slicer source missed");

	property p_invalid;
		@(posedge clock) disable iff (rst)
		(slicer_in_invalid && c.det_en[POS_SLICER_INVALID_EN]) |=> c.loss;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("invalid level source missed");

	property p_det_rst;
		@(posedge clock) rst |=> c.det_en == DET_EN_RST[DET_EN_W-1:0];
	endproperty
	a_det_rst: assert property (p_det_rst)
		else $error("enable register reset value wrong");

	property p_down_lat;
		@(posedge clock) disable iff (rst)
		##1 c.down_lat == ($past(det) || ($past(c.down_lat) && !$past(link_up_start)));
	endproperty
	a_down_lat: assert property (p_down_lat)
		else $error("link down latch wrong");

	property p_halt;
		@(posedge clock) disable iff (rst) c.halt |-> $past(c.stop_en);
	endproperty
	a_halt: assert property (p_halt)
		else $error("clock halted while not allowed");

	property p_stop_rst;
		@(posedge clock) rst |=> c.stop_en;
	endproperty
	a_stop_rst: assert property (p_stop_rst)
		else $error("clock stop reset value wrong");

	property p_ro_write;
		@(posedge clock) disable iff (rst)
		(wr_ev && m.addr == OFF_PARTNER && !an_partner_valid) |=> $stable(c.partner);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write changed partner ability");

	// Main scenarios
	c_write_det: cover property (@(posedge clock) disable iff (rst) wr_ev && m.addr == OFF_DET_EN);
	c_read: cover property (@(posedge clock) disable iff (rst) rd_ev && m.addr == OFF_SQ_ERR);
	c_down: cover property (@(posedge clock) disable iff (rst) $rose(c.down_lat));
	c_halt: cover property (@(posedge clock) disable iff (rst) $rose(c.halt));
endmodule
`default_nettype wire

// ### test/eelsr_mdio_host.sv
// Management host model: makes mdc and sends whole frames.
// Assumes the bench resolves the pulled-up data line into line.
`timescale 1ns/100ps
`default_nettype none
module eelsr_mdio_host (
	output logic mdc,
	output logic h_bit,
	output logic h_oe,
	input wire logic line
);
	import eelsr_pkg::*;
	// Clock stands low between frames; line released
	initial begin
		mdc = 1'b0;
		h_bit = 1'b1;
		h_oe = 1'b0;
	end
	// Spare edges so the mdc side sees reset come and go
	task automatic idle(input int n);
		// Start a few ns off the core clock edges so the two domains never share an edge
		#(1 + (8 - $time % 8) % 8);
		repeat (n) begin
			#24 mdc = 1'b1;
			#24 mdc = 1'b0;
		end
	endtask
	// Host lets go from turnaround on reads; samples just before each rise of the 16 data bits
	task automatic frame(input logic [1:0] op, input logic [15:0] d, output logic [15:0] q);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'h0, op, PHY_ADDR, MMD_DEV, 2'h2, d};
		q = 16'h0000;
		// At least one step after the last release, and off the core clock edges
		#(1 + (8 - $time % 8) % 8);
		for (int i = 0; i < 64; i++) begin
			h_oe = !(op[1] && i >= 46);
			h_bit = bits[63 - i];
			#24;
			if (i >= 48) q = {q[14:0], line};
			mdc = 1'b1;
			#24 mdc = 1'b0;
		end
		h_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### test/eelsr_regs_test.sv
// Self-checking bench for the EEE and link status registers.
// Assumes the host model and a pull-up on the data line.
`timescale 1ns/100ps
`default_nettype none
module eelsr_regs_test;
	import eelsr_pkg::*;
	localparam int LIMIT = 60000;
	logic clock, rst, mdc, mdio_out, mdio_oe, h_bit, h_oe, mdio_in;
	logic an_partner_valid, link_up, link_up_100, link_up_start, eee_resolved, rx_lpi;
	logic early_link_down_latched, link_loss, rx_clk_stop_allowed, rx_clk_halt;
	logic [5:0] an_partner_eee;
	logic [7:0] sq_err_in;
	logic [3:0] src;
	logic [15:0] q, d;
	logic [15:0] ra [7] = '{OFF_PARTNER, OFF_RESOLVED, OFF_SQ_ERR, OFF_DET_EN, OFF_DOWN_LAT, OFF_CLK_STOP, 16'h8003};
	logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h003D, 16'h0000, 16'h0400, 16'h0000};
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 32'h31e92367;
	// Pull-up wins when nobody drives
	assign mdio_in = mdio_oe ? mdio_out : (h_oe ? h_bit : 1'b1);
	eelsr_regs u_eelsr_regs (.clock(clock), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .an_partner_eee(an_partner_eee), .an_partner_valid(an_partner_valid),
		.link_up(link_up), .link_up_100(link_up_100), .link_up_start(link_up_start),
		.eee_resolved(eee_resolved), .sq_err_in(sq_err_in), .rx_lpi(rx_lpi), .pcs_rx_error(src[3]),
		.slicer_out_stuck(src[2]), .slicer_in_zero(src[1]), .slicer_in_invalid(src[0]),
		.early_link_down_latched(early_link_down_latched), .link_loss(link_loss),
		.rx_clk_stop_allowed(rx_clk_stop_allowed), .rx_clk_halt(rx_clk_halt));
	eelsr_mdio_host u_eelsr_mdio_host (.mdc(mdc), .h_bit(h_bit), .h_oe(h_oe), .line(mdio_in));
	// Core clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		logic [15:0] x;
		u_eelsr_mdio_host.frame(OP_ADDR, a, x);
		u_eelsr_mdio_host.frame(OP_WRITE, v, x);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		logic [15:0] x;
		u_eelsr_mdio_host.frame(OP_ADDR, a, x);
		u_eelsr_mdio_host.frame(2'h3, 16'h0000, v);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Any source whose own enable is set reports loss
	function automatic logic exp_loss(input logic [15:0] en, input logic [3:0] s);
		return (en[7] & s[3]) | (en[5] & s[2]) | (en[3] & s[1]) | (en[1] & s[0]);
	endfunction
	// Main sequence
	initial begin
		rst = 1'b1;
		{an_partner_eee, an_partner_valid, link_up, link_up_100, link_up_start} = '0;
		{eee_resolved, sq_err_in, rx_lpi, src} = '0;
		fork
			ticks(16);
			u_eelsr_mdio_host.idle(4);
		join
		@(posedge clock);
		rst <= 1'b0;
		u_eelsr_mdio_host.idle(4);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], q);
			check(q, rv[i]);
		end
		$display("reset values done");
		repeat (3) begin
			@(posedge clock);
			an_partner_eee <= 6'($random(seed));
			an_partner_valid <= 1'b1;
			@(posedge clock);
			an_partner_valid <= 1'b0;
			d = {9'h000, an_partner_eee, 1'b0};
			wr(OFF_PARTNER, 16'hFFFF);
			rd(OFF_PARTNER, q);
			check(q, d);
		end
		// Read with increment steps the address on to the partner register
		u_eelsr_mdio_host.frame(OP_ADDR, OFF_PARTNER - 16'h0001, q);
		u_eelsr_mdio_host.frame(OP_RD_INC, 16'h0000, q);
		check(q, 16'h0000);
		u_eelsr_mdio_host.frame(2'h3, 16'h0000, q);
		check(q, d);
		$display("partner ability done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			link_up_100 <= i[0];
			link_up <= i[1];
			eee_resolved <= 1'($random(seed));
			sq_err_in <= 8'($random(seed));
			ticks(2);
			rd(OFF_RESOLVED, q);
			check(q, {15'h0000, link_up & eee_resolved});
			rd(OFF_SQ_ERR, q);
			check(q, link_up_100 ? {8'h00, sq_err_in} : 16'h0000);
		end
		$display("status done");
		repeat (6) begin
			// Reserved bits of the low byte go back at their reset values; the upper byte is random
			d = {8'($random(seed)), (8'($random(seed)) & 8'hAA) | 8'h15};
			wr(OFF_DET_EN, d);
			rd(OFF_DET_EN, q);
			check(q, {8'h00, d[7:0]});
			repeat (4) begin
				@(posedge clock);
				src <= 4'($random(seed));
				ticks(2);
				check(link_loss, exp_loss(d, src));
			end
		end
		$display("detect enables done");
		wr(OFF_DET_EN, 16'h00BD);
		// Clear what the random sources left latched, so the set below is seen
		@(posedge clock);
		src <= 4'h0;
		link_up_start <= 1'b1;
		@(posedge clock);
		link_up_start <= 1'b0;
		ticks(2);
		check(early_link_down_latched, 1'b0);
		@(posedge clock);
		src <= 4'h8;
		ticks(2);
		src <= 4'h0;
		ticks(4);
		check(early_link_down_latched, 1'b1);
		wr(OFF_DOWN_LAT, 16'h0000);
		rd(OFF_DOWN_LAT, q);
		check(q, 16'h2000);
		@(posedge clock);
		link_up_start <= 1'b1;
		@(posedge clock);
		link_up_start <= 1'b0;
		ticks(2);
		check(early_link_down_latched, 1'b0);
		$display("latch done");
		rx_lpi <= 1'b1;
		ticks(3);
		check(rx_clk_halt, 1'b1);
		wr(OFF_CLK_STOP, 16'hFBFF);
		rd(OFF_CLK_STOP, q);
		check(q, 16'h0000);
		check(rx_clk_halt, 1'b0);
		check(rx_clk_stop_allowed, 1'b0);
		wr(OFF_CLK_STOP, 16'hFFFF);
		rd(OFF_CLK_STOP, q);
		check(q, 16'h0400);
		$display("clock stop done");
		results();
	end
endmodule
`default_nettype wire
